//--- include/tpd_consts.svh
/*
  offsets, field positions, reset values and scale codes for the touch pattern detector.
  assumes nothing beyond a plain include by bare name.
*/
`ifndef TPD_CONSTS_SVH
`define TPD_CONSTS_SVH

`define TPD_ADDR_W 8
`define TPD_OFF_PATTERN_CONFIG 8'h2b
`define TPD_OFF_PATTERN_SELECT 8'h2d
`define TPD_OFF_BASELINE_RANGE 8'h2e
`define TPD_RST_PATTERN_CONFIG 8'h00
`define TPD_RST_PATTERN_SELECT 8'h3f
`define TPD_RST_BASELINE_RANGE 8'h00
`define TPD_BIT_DETECT_ENABLE 7
`define TPD_BIT_TH_SEL_HI 3
`define TPD_BIT_TH_SEL_LO 2
`define TPD_BIT_MATCH_MODE 1
`define TPD_BIT_ALERT_ENABLE 0
`define TPD_TH_CODE_12P5 2'h0
`define TPD_TH_CODE_25 2'h1
`define TPD_TH_CODE_37P5 2'h2
`define TPD_TH_CODE_100 2'h3
`define TPD_SEL_MASK 8'h3f
`define TPD_CFG_MASK 8'h8f

`endif

//--- include/tpd_pkg.sv
/*
  types for the touch pattern detector.
  assumes tpd_consts.svh for numeric values.
*/
package tpd_pkg;

  typedef struct packed {
    logic detect_enable;
    logic [1:0] th_select;
    logic match_mode;
    logic alert_enable;
  } tpd_config_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpd_reg_req_t;

  typedef enum logic {
    TPD_MODE_COUNT,
    TPD_MODE_SPECIFIC
  } tpd_mode_t;

endpackage : tpd_pkg

//--- src/tpd_detector.sv
/*
  touch pattern detector: per-cycle pattern/count match, blocking, event flag,
  alert, and baseline out-of-range status with summary bit.
  assumes the serial port delivers one-cycle register strobes, and the sensing
  core gives a cycle-end strobe with deltas, thresholds and noise flags valid.
*/
`timescale 1ns/1ps
`include "tpd_consts.svh"

module tpd_detector #(
  parameter int NUM_INPUTS = 6,
  parameter int DELTA_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire tpd_pkg::tpd_reg_req_t i_reg_req,
  input wire logic i_cycle_end,
  input wire logic [NUM_INPUTS*DELTA_W-1:0] i_delta,
  input wire logic [NUM_INPUTS*7-1:0] i_touch_threshold,
  input wire logic [6:0] i_standby_threshold,
  input wire logic [NUM_INPUTS-1:0] i_standby_input,
  input wire logic [NUM_INPUTS-1:0] i_noise_flag,
  input wire logic [NUM_INPUTS-1:0] i_baseline_out,
  input wire logic i_event_clear,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_touch_block,
  output logic o_pattern_event_flag,
  output logic o_alert,
  output logic o_baseline_out_of_range_summary
);

  logic [7:0] config_reg;
  logic [7:0] select_reg;
  logic [7:0] baseline_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic block_reg;
  logic flag_reg;
  logic alert_reg;
  logic summary_reg;
  logic cond_reg;

  tpd_pkg::tpd_config_t cfg;
  assign cfg.detect_enable = config_reg[`TPD_BIT_DETECT_ENABLE];
  assign cfg.th_select = config_reg[`TPD_BIT_TH_SEL_HI:`TPD_BIT_TH_SEL_LO];
  assign cfg.match_mode = config_reg[`TPD_BIT_MATCH_MODE];
  assign cfg.alert_enable = config_reg[`TPD_BIT_ALERT_ENABLE];

  function automatic logic [DELTA_W+2:0] scale_th(input logic [6:0] th, input logic [1:0] sel);
    logic [DELTA_W+2:0] base8;
    base8 = (DELTA_W+3)'(th);
    unique case (sel)
      `TPD_TH_CODE_12P5: scale_th = base8;
      `TPD_TH_CODE_25: scale_th = base8 << 1;
      `TPD_TH_CODE_37P5: scale_th = (base8 << 1) + base8;
      `TPD_TH_CODE_100: scale_th = base8 << 3;
    endcase
  endfunction : scale_th

  function automatic logic [3:0] pop_count(input logic [NUM_INPUTS-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < NUM_INPUTS; k++) begin
      n = n + 4'(v[k]);
    end
    pop_count = n;
  endfunction : pop_count

  // qualifying vector, compared in eighths of a threshold
  logic [NUM_INPUTS-1:0] qualify;
  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g++) begin : g_qual
      wire logic [6:0] own_th = i_touch_threshold[g*7 +: 7];
      wire logic [6:0] use_th = i_standby_input[g] ? i_standby_threshold : own_th;
      wire logic [DELTA_W+2:0] th8 = scale_th(use_th, cfg.th_select);
      wire logic [DELTA_W+2:0] delta8 = {i_delta[g*DELTA_W +: DELTA_W], 3'h0};
      assign qualify[g] = (delta8 > th8) || i_noise_flag[g];
    end
  endgenerate

  wire logic [NUM_INPUTS-1:0] pattern = select_reg[NUM_INPUTS-1:0];
  wire tpd_pkg::tpd_mode_t mode = tpd_pkg::tpd_mode_t'(cfg.match_mode);
  wire logic count_hit = pop_count(qualify) >= pop_count(pattern);
  wire logic specific_hit = (qualify & pattern) == pattern;
  wire logic mode_hit = (mode == tpd_pkg::TPD_MODE_SPECIFIC) ? specific_hit : count_hit;
  wire logic hit = cfg.detect_enable && mode_hit;

  wire logic eval = i_enable && i_cycle_end;
  wire logic cond_next = eval ? hit : (cond_reg && cfg.detect_enable);
  wire logic new_event = eval && hit;
  wire logic clear_ok = i_event_clear && !cond_next;
  wire logic flag_next = new_event || (flag_reg && !clear_ok);

  wire logic wr_cfg = i_reg_req.write && i_reg_req.addr == `TPD_OFF_PATTERN_CONFIG;
  wire logic wr_sel = i_reg_req.write && i_reg_req.addr == `TPD_OFF_PATTERN_SELECT;
  wire logic [7:0] cfg_wmask = `TPD_CFG_MASK;
  wire logic [7:0] read_mux =
    (i_reg_req.addr == `TPD_OFF_PATTERN_CONFIG) ? (config_reg & cfg_wmask) :
    (i_reg_req.addr == `TPD_OFF_PATTERN_SELECT) ? select_reg :
    (i_reg_req.addr == `TPD_OFF_BASELINE_RANGE) ? baseline_reg : 8'h00;
  wire logic [7:0] baseline_next = {2'h0, i_baseline_out};

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      config_reg <= `TPD_RST_PATTERN_CONFIG;
      select_reg <= `TPD_RST_PATTERN_SELECT;
    end else if (i_enable) begin
      if (wr_cfg) begin
        config_reg <= i_reg_req.wdata & cfg_wmask;
      end
      if (wr_sel) begin
        select_reg <= i_reg_req.wdata & `TPD_SEL_MASK;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      baseline_reg <= `TPD_RST_BASELINE_RANGE;
      summary_reg <= 1'b0;
    end else if (i_enable) begin
      rvalid_reg <= i_reg_req.read;
      if (i_reg_req.read) begin
        rdata_reg <= read_mux;
      end
      baseline_reg <= baseline_next;
      summary_reg <= |i_baseline_out;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cond_reg <= 1'b0;
      block_reg <= 1'b0;
      flag_reg <= 1'b0;
      alert_reg <= 1'b0;
    end else if (i_enable) begin
      cond_reg <= cond_next;
      block_reg <= cond_next;
      flag_reg <= flag_next;
      alert_reg <= flag_next && cfg.alert_enable;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rvalid = rvalid_reg;
  assign o_touch_block = block_reg;
  assign o_pattern_event_flag = flag_reg;
  assign o_alert = alert_reg;
  assign o_baseline_out_of_range_summary = summary_reg;

endmodule : tpd_detector

//--- bench/tpd_checker.sv
/*
  port-level assertions for the touch pattern detector.
  assumes one clock, async active-high reset, bound to tpd_detector.
*/
`timescale 1ns/1ps
module tpd_checker #(
  parameter int NUM_INPUTS = 6
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire tpd_pkg::tpd_reg_req_t i_reg_req,
  input wire logic i_cycle_end,
  input wire logic [NUM_INPUTS-1:0] i_baseline_out,
  input wire logic i_event_clear,
  input wire logic o_rvalid,
  input wire logic o_touch_block,
  input wire logic o_pattern_event_flag,
  input wire logic o_alert,
  input wire logic o_baseline_out_of_range_summary
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_read_answered: assert property (i_enable && i_reg_req.read |=> o_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (o_rvalid |-> $past(i_enable && i_reg_req.read))
    else $error("stray read valid");
  a_summary_follows: assert property (i_enable |=>
    o_baseline_out_of_range_summary == $past(|i_baseline_out)) else $error("summary wrong");
  a_alert_needs_flag: assert property (o_alert |-> o_pattern_event_flag)
    else $error("alert without flag");
  a_block_sets_flag: assert property ($rose(o_touch_block) |-> o_pattern_event_flag)
    else $error("block without flag");
  a_flag_fall_cause: assert property ($fell(o_pattern_event_flag) |-> $past(i_event_clear))
    else $error("flag dropped without clear");
  a_flag_rise_cause: assert property ($rose(o_pattern_event_flag) |->
    $past(i_cycle_end && i_enable)) else $error("flag set outside cycle end");
  a_block_change_cause: assert property ($changed(o_touch_block) |->
    $past(i_cycle_end || i_reg_req.write)) else $error("block changed without cause");
endmodule : tpd_checker

bind tpd_detector tpd_checker #(.NUM_INPUTS(NUM_INPUTS)) tpd_checker_i (.*);

//--- bench/tpd_host_model.sv
/*
  host side: single-byte register accesses and the event clear.
  assumes requests launch after a rising edge and are taken at the next.
*/
`timescale 1ns/1ps
module tpd_host_model (
  input wire logic i_clk,
  output tpd_pkg::tpd_reg_req_t o_req,
  output logic o_clear,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  initial begin
    o_req = '0;
    o_clear = 1'b0;
  end
  task automatic access(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge i_clk);
    o_req <= '{wr, !wr, a, d};
    @(posedge i_clk);
    o_req <= '0;
    #1 q = i_rvalid ? i_rdata : ~i_rdata;
  endtask : access
  task automatic clear_flag;
    @(posedge i_clk);
    o_clear <= 1'b1;
    @(posedge i_clk);
    o_clear <= 1'b0;
    #1;
  endtask : clear_flag
endmodule : tpd_host_model

//--- bench/testbench.sv
/*
  self-checking bench for the touch pattern detector.
  assumes the host model for register traffic.
*/
`timescale 1ns/1ps
`include "tpd_consts.svh"
module testbench;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_enable = 1'b1;
  logic i_cycle_end = 1'b0;
  logic [47:0] i_delta = '0;
  logic [6:0] i_standby_threshold = 7'h10;
  logic [5:0] i_standby_input = '0;
  logic [5:0] i_noise_flag = '0;
  logic [5:0] i_baseline_out = '0;
  tpd_pkg::tpd_reg_req_t req;
  logic clear, o_rvalid, o_touch_block, o_pattern_event_flag, o_alert;
  logic o_baseline_out_of_range_summary;
  logic [7:0] o_rdata, q;
  logic [7:0] mult [4] = '{8'h01, 8'h02, 8'h03, 8'h08};
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  tpd_detector tpd_detector_i (.i_clk, .i_reset, .i_enable, .i_reg_req(req), .i_cycle_end,
    .i_delta, .i_touch_threshold({6{7'h08}}), .i_standby_threshold, .i_standby_input,
    .i_noise_flag, .i_baseline_out, .i_event_clear(clear), .o_rdata, .o_rvalid, .o_touch_block,
    .o_pattern_event_flag, .o_alert, .o_baseline_out_of_range_summary);
  tpd_host_model tpd_host_model_i (.i_clk, .o_req(req), .o_clear(clear), .i_rdata(o_rdata),
    .i_rvalid(o_rvalid));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, exp);
    tpd_host_model_i.access(1'b0, a, 8'h00, q);
    check("rdata", q, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, d);
    tpd_host_model_i.access(1'b1, a, d, q);
  endtask : wr
  task automatic sense(input logic [7:0] d1, input logic [5:0] nz, input logic eb);
    @(posedge i_clk);
    i_delta <= {40'h0, d1};
    i_noise_flag <= nz;
    i_cycle_end <= 1'b1;
    @(posedge i_clk);
    i_cycle_end <= 1'b0;
    #1 check("block", 8'(o_touch_block), 8'(eb));
  endtask : sense
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(`TPD_OFF_PATTERN_CONFIG, 8'h00);
    rd(`TPD_OFF_PATTERN_SELECT, 8'h3f);
    rd(8'h2c, 8'h00);
    i_baseline_out <= 6'h25;
    wr(`TPD_OFF_BASELINE_RANGE, 8'h00);
    rd(`TPD_OFF_BASELINE_RANGE, 8'h25);
    check("summary", 8'(o_baseline_out_of_range_summary), 8'h01);
    sense(8'hff, 6'h3f, 1'b0);
    $display("test registers done");
    wr(`TPD_OFF_PATTERN_SELECT, 8'hc1);
    rd(`TPD_OFF_PATTERN_SELECT, 8'h01);
    foreach (mult[c]) begin
      wr(`TPD_OFF_PATTERN_CONFIG, {4'h8, c[1:0], 2'h2});
      sense(mult[c], 6'h3e, 1'b0);
      sense(mult[c] + 8'h01, 6'h00, 1'b1);
    end
    check("alert", 8'(o_alert), 8'h00);
    tpd_host_model_i.clear_flag();
    check("flag", 8'(o_pattern_event_flag), 8'h01);
    sense(8'h00, 6'h00, 1'b0);
    tpd_host_model_i.clear_flag();
    check("flag", 8'(o_pattern_event_flag), 8'h00);
    $display("test scaling done");
    wr(`TPD_OFF_PATTERN_CONFIG, 8'hff);
    rd(`TPD_OFF_PATTERN_CONFIG, 8'h8f);
    i_standby_input <= 6'h01;
    sense(8'h09, 6'h00, 1'b0);
    sense(8'h11, 6'h00, 1'b1);
    check("alert", 8'(o_alert), 8'h01);
    wr(`TPD_OFF_PATTERN_SELECT, 8'h07);
    wr(`TPD_OFF_PATTERN_CONFIG, 8'h81);
    sense(8'h00, 6'h30, 1'b0);
    sense(8'h00, 6'h38, 1'b1);
    $display("test modes done");
    i_enable <= 1'b0;
    sense(8'h00, 6'h00, 1'b1);
    i_enable <= 1'b1;
    sense(8'h00, 6'h00, 1'b0);
    $display("test clock enable done");
    complete_run();
  end
endmodule : testbench
